// ==== common/usb_port_pkg.sv ====
// Constants and types for the USB port role and fault block
//
// Contract
// - Enable low opens both switches; supply low does too except on the first stand-alone option with role high; role pin high on register parts: charger only.
// - Register part, select 00, role low: pass switch closed, charger switch open.
// - Register part, select 01: auto CDP, switch follows charging-detection state.
// - Register part, select 10: dedicated charging, 2.4 A bias, charger switch only.
// - Register part, select 11: dedicated charging, 1 A bias, charger switch only.
// - Stand-alone: enable low opens both; supply low with role low is invalid, both open.
// - First stand-alone option: role low auto CDP; role high 2.4 A charging always.
// - Second stand-alone option: role low pass-through, role high auto CDP.
// - Third stand-alone option: role low pass-through, role high 2.4 A charging.
// - Register parts default to auto CDP or pass-through after enable rises.
// - Enable rise loads strap settings into registers; host may overwrite later.
// - Register parts: first strap gives spread-spectrum, sync direction, address low bits.
// - Stand-alone: first strap gives switching frequency, sync direction, spread-spectrum.
// - Stand-alone: second strap gives gain low bits; third gives gain top, limit, hold.
// - The option without hold mode ignores strap hold requests.
// - Stand-alone parts read the serial data and clock pins as straps two and three.
// - Fault output stays asserted while any fault persists, releases when all clear.
// - Error flags clear on read and set again while their fault remains.
// - Two mask words choose which error flags drive the interrupt output.
// - Interrupt releases on read of the error word and reasserts if fault remains.
// - Fault output is open-drain active low, filtered by deglitch and blanking.
// - Shared open-drain output is attach indicator on stand-alone, interrupt otherwise.
// - Changing between communication and dedicated charging roles performs a port reset.
package usb_port_pkg;

    // ----------------------------------------------------------------
    // Variants and modes
    // ----------------------------------------------------------------
    typedef enum {
        VAR_REG_CDP_DEFAULT,
        VAR_REG_SDP_DEFAULT,
        VAR_SA_FIRST,
        VAR_SA_SECOND,
        VAR_SA_THIRD
    } variant_t;

    typedef enum {
        MODE_OFF,
        MODE_INVALID_OPEN,
        MODE_INVALID_CHG,
        MODE_SDP,
        MODE_CDP,
        MODE_DCP_24,
        MODE_DCP_1
    } mode_t;

    // ----------------------------------------------------------------
    // Charge-detect select encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] CD_SDP = 2'h0;
    localparam logic [1:0] CD_CDP = 2'h1;
    localparam logic [1:0] CD_DCP_24 = 2'h2;
    localparam logic [1:0] CD_DCP_1 = 2'h3;

    // ----------------------------------------------------------------
    // Strap step field positions
    // ----------------------------------------------------------------
    localparam int STRAP_W = 4;
    localparam int S1_SS_OFF_BIT = 3;
    localparam int S1_SYNC_OUT_BIT = 2;
    localparam int S3_HOLD_BIT = 3;
    localparam int S3_GAIN_MSB_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic RST_SS_EN = 1'b1;
    localparam logic RST_SYNC_DIR = 1'b0;
    localparam logic [1:0] RST_ADDR_LSB = 2'h0;
    localparam logic [1:0] RST_FREQ_SEL = 2'h0;
    localparam logic [4:0] RST_GAIN = 5'h00;
    localparam logic [1:0] RST_ILIM = 2'h0;
    localparam logic RST_HOLD = 1'b0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int PORT_RESET_TIME_US = 100;
    localparam int PORT_RESET_CYCLES = PORT_RESET_TIME_US * CLK_MHZ;
    localparam int DEGLITCH_TIME_US = 16;
    localparam int DEGLITCH_CYCLES = DEGLITCH_TIME_US * CLK_MHZ;
    localparam int BLANK_TIME_US = 2000;
    localparam int BLANK_CYCLES = BLANK_TIME_US * CLK_MHZ;

endpackage

// ==== rtl/bit_sync.sv ====
// Two-flop synchroniser for independent level inputs
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_q
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second; bits are not coherent as a word
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end
endmodule // bit_sync
`default_nettype wire

// ==== rtl/fault_qualify.sv ====
// Deglitch and startup blanking filter for the fault indication
`timescale 1ns/1ps
`default_nettype none
module fault_qualify #(
    parameter int DEGLITCH = 160,
    parameter int BLANK = 20000
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic fault_cond,
    output logic fault_q
);
    localparam int DW = $clog2(DEGLITCH + 1);
    localparam int BW = $clog2(BLANK + 1);
    localparam logic [DW-1:0] DEG_MAX = DW'(DEGLITCH);
    localparam logic [BW-1:0] BLK_MAX = BW'(BLANK);

    logic [DW-1:0] deg_d, deg_q;
    logic [BW-1:0] blk_d, blk_q;
    logic fault_d;

    // Blanking restarts at each startup; deglitch needs an unbroken run
    always_comb
    begin
        blk_d = blk_q;
        if (start)
            blk_d = BLK_MAX;
        else if (blk_q != '0)
            blk_d = blk_q - 1'b1;
        deg_d = '0;
        if (fault_cond)
            deg_d = (deg_q == DEG_MAX) ? deg_q : deg_q + 1'b1;
        // Held while the fault persists after blanking
        fault_d = fault_cond && (deg_q == DEG_MAX) && (blk_q == '0);
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            deg_q <= '0;
            blk_q <= '0;
            fault_q <= 1'b0;
        end
        else
        begin
            deg_q <= deg_d;
            blk_q <= blk_d;
            fault_q <= fault_d;
        end
    end
endmodule // fault_qualify
`default_nettype wire

// ==== rtl/usb_port_mode_and_fault_ctrl.sv ====
// Data switch role decode, strap loading and fault/alert reporting
`timescale 1ns/1ps
`default_nettype none
module usb_port_mode_and_fault_ctrl #(
    parameter usb_port_pkg::variant_t VARIANT = usb_port_pkg::VAR_REG_CDP_DEFAULT,
    parameter int ERR_W = 8,
    parameter int DEGLITCH_CYCLES = usb_port_pkg::DEGLITCH_CYCLES,
    parameter int BLANK_CYCLES = usb_port_pkg::BLANK_CYCLES,
    parameter int PORT_RESET_CYCLES = usb_port_pkg::PORT_RESET_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic accessory_power_enable,
    input wire logic logic_supply_ok,
    input wire logic port_role_pin,
    input wire logic cdp_charging_state,
    input wire logic device_attached,
    input wire logic fault_condition,
    input wire logic [ERR_W-1:0] err_cond_first,
    input wire logic [ERR_W-1:0] err_cond_second,
    input wire logic [3:0] strap_one,
    input wire logic [3:0] strap_two,
    input wire logic [3:0] strap_three,
    input wire logic host_cfg_wr,
    input wire logic [1:0] host_cd,
    input wire logic host_ss_en,
    input wire logic host_sync_dir,
    input wire logic err_first_rd,
    input wire logic err_second_rd,
    input wire logic [ERR_W-1:0] alert_mask_first,
    input wire logic [ERR_W-1:0] alert_mask_second,
    output logic pass_switch_q,
    output logic charger_switch_q,
    output logic bias_1a_q,
    output logic port_reset_q,
    output logic [1:0] charge_detect_select_q,
    output logic ss_en_q,
    output logic sync_dir_q,
    output logic [1:0] addr_lsb_q,
    output logic [1:0] freq_sel_q,
    output logic [4:0] gain_q,
    output logic [1:0] ilim_sel_q,
    output logic hold_en_q,
    output logic [ERR_W-1:0] err_first_q,
    output logic [ERR_W-1:0] err_second_q,
    output logic fault_pin_o_q,
    output logic fault_pin_oe_n_q,
    output logic alert_pin_o_q,
    output logic alert_pin_oe_n_q
);
    localparam int SW = 18 + 2 * ERR_W;
    localparam int RW = $clog2(PORT_RESET_CYCLES + 1);
    localparam logic [RW-1:0] RST_MAX = RW'(PORT_RESET_CYCLES);
    localparam bit IS_REG = (VARIANT == usb_port_pkg::VAR_REG_CDP_DEFAULT) ||
        (VARIANT == usb_port_pkg::VAR_REG_SDP_DEFAULT);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------

    // Role from pins and select bits
    function automatic usb_port_pkg::mode_t decode_mode(input logic en, input logic sup,
        input logic role, input logic [1:0] cd);
        if (!en)
            decode_mode = usb_port_pkg::MODE_OFF;
        else if (IS_REG)
        begin
            if (!sup)
                decode_mode = usb_port_pkg::MODE_OFF;
            else if (role)
                decode_mode = usb_port_pkg::MODE_INVALID_CHG;
            else
                unique case (cd)
                    usb_port_pkg::CD_SDP: decode_mode = usb_port_pkg::MODE_SDP;
                    usb_port_pkg::CD_CDP: decode_mode = usb_port_pkg::MODE_CDP;
                    usb_port_pkg::CD_DCP_24: decode_mode = usb_port_pkg::MODE_DCP_24;
                    usb_port_pkg::CD_DCP_1: decode_mode = usb_port_pkg::MODE_DCP_1;
                endcase
        end
        else if (!sup && !role)
            decode_mode = usb_port_pkg::MODE_INVALID_OPEN;
        else if (VARIANT == usb_port_pkg::VAR_SA_FIRST)
            decode_mode = role ? usb_port_pkg::MODE_DCP_24 : usb_port_pkg::MODE_CDP;
        else if (!sup)
            decode_mode = usb_port_pkg::MODE_OFF; // Unlisted case kept safe
        else if (VARIANT == usb_port_pkg::VAR_SA_SECOND)
            decode_mode = role ? usb_port_pkg::MODE_CDP : usb_port_pkg::MODE_SDP;
        else
            decode_mode = role ? usb_port_pkg::MODE_DCP_24 : usb_port_pkg::MODE_SDP;
    endfunction

    // Dedicated charging roles, to spot a role-class change
    function automatic logic is_dcp(input usb_port_pkg::mode_t m);
        is_dcp = (m == usb_port_pkg::MODE_DCP_24) || (m == usb_port_pkg::MODE_DCP_1);
    endfunction

    function automatic logic is_active(input usb_port_pkg::mode_t m);
        is_active = (m == usb_port_pkg::MODE_SDP) || (m == usb_port_pkg::MODE_CDP) || is_dcp(m);
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [SW-1:0] sync_s;
    logic en_s, sup_s, role_s, chg_state_s, attach_s, fault_s;
    logic [3:0] s1_s, s2_s, s3_s;
    logic [ERR_W-1:0] ec1_s, ec2_s;

    // Stand-alone straps two and three use the serial bus pins
    bit_sync #(.WIDTH(SW)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({accessory_power_enable, logic_supply_ok, port_role_pin, cdp_charging_state,
            device_attached, fault_condition, strap_one, strap_two, strap_three,
            err_cond_first, err_cond_second}),
        .sync_q(sync_s)
    );

    assign {en_s, sup_s, role_s, chg_state_s, attach_s, fault_s, s1_s, s2_s, s3_s,
        ec1_s, ec2_s} = sync_s;

    // ----------------------------------------------------------------
    // Startup and configuration registers
    // ----------------------------------------------------------------
    logic en_prev_q, en_rise;
    logic [1:0] cd_d;
    logic ss_en_d, sync_dir_d, hold_en_d;
    logic [1:0] addr_lsb_d, freq_sel_d, ilim_sel_d;
    logic [4:0] gain_d;

    assign en_rise = en_s && !en_prev_q;

    // Straps load only on the shutdown-to-active edge, host writes win afterwards
    always_comb
    begin
        cd_d = charge_detect_select_q;
        ss_en_d = ss_en_q;
        sync_dir_d = sync_dir_q;
        addr_lsb_d = addr_lsb_q;
        freq_sel_d = freq_sel_q;
        gain_d = gain_q;
        ilim_sel_d = ilim_sel_q;
        hold_en_d = hold_en_q;
        if (en_rise)
        begin
            cd_d = (VARIANT == usb_port_pkg::VAR_REG_SDP_DEFAULT) ?
                usb_port_pkg::CD_SDP : usb_port_pkg::CD_CDP;
            ss_en_d = !s1_s[usb_port_pkg::S1_SS_OFF_BIT];
            sync_dir_d = s1_s[usb_port_pkg::S1_SYNC_OUT_BIT];
            if (IS_REG)
                addr_lsb_d = s1_s[1:0];
            else
            begin
                freq_sel_d = s1_s[1:0];
                gain_d = {s3_s[usb_port_pkg::S3_GAIN_MSB_BIT], s2_s};
                ilim_sel_d = s3_s[1:0];
                // The option without hold mode drops them
                hold_en_d = s3_s[usb_port_pkg::S3_HOLD_BIT] &&
                    (VARIANT != usb_port_pkg::VAR_SA_SECOND);
            end
        end
        else if (host_cfg_wr && IS_REG)
        begin
            cd_d = host_cd;
            ss_en_d = host_ss_en;
            sync_dir_d = host_sync_dir;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en_prev_q <= 1'b0;
            charge_detect_select_q <= usb_port_pkg::CD_SDP;
            ss_en_q <= usb_port_pkg::RST_SS_EN;
            sync_dir_q <= usb_port_pkg::RST_SYNC_DIR;
            addr_lsb_q <= usb_port_pkg::RST_ADDR_LSB;
            freq_sel_q <= usb_port_pkg::RST_FREQ_SEL;
            gain_q <= usb_port_pkg::RST_GAIN;
            ilim_sel_q <= usb_port_pkg::RST_ILIM;
            hold_en_q <= usb_port_pkg::RST_HOLD;
        end
        else
        begin
            en_prev_q <= en_s;
            charge_detect_select_q <= cd_d;
            ss_en_q <= ss_en_d;
            sync_dir_q <= sync_dir_d;
            addr_lsb_q <= addr_lsb_d;
            freq_sel_q <= freq_sel_d;
            gain_q <= gain_d;
            ilim_sel_q <= ilim_sel_d;
            hold_en_q <= hold_en_d;
        end
    end

    // ----------------------------------------------------------------
    // Data switch control and port reset
    // ----------------------------------------------------------------
    usb_port_pkg::mode_t mode;
    logic dcp_class_d, dcp_class_q;
    logic [RW-1:0] prst_d, prst_q;
    logic pass_d, chg_d, bias_1a_d, port_reset_d;

    assign mode = decode_mode(en_s, sup_s, role_s, charge_detect_select_q);

    // A role-class flip holds both switches open so the attached side re-detects
    always_comb
    begin
        dcp_class_d = dcp_class_q;
        prst_d = (prst_q != '0) ? prst_q - 1'b1 : prst_q;
        if (is_active(mode))
        begin
            dcp_class_d = is_dcp(mode);
            if (is_dcp(mode) != dcp_class_q)
                prst_d = RST_MAX;
        end
        {pass_d, chg_d} = 2'h0;
        unique case (mode)
            usb_port_pkg::MODE_SDP: pass_d = 1'b1;
            usb_port_pkg::MODE_CDP:
            begin
                pass_d = !chg_state_s;
                chg_d = chg_state_s;
            end
            usb_port_pkg::MODE_DCP_24, usb_port_pkg::MODE_DCP_1,
            usb_port_pkg::MODE_INVALID_CHG: chg_d = 1'b1;
            usb_port_pkg::MODE_OFF, usb_port_pkg::MODE_INVALID_OPEN: pass_d = 1'b0;
        endcase
        port_reset_d = (prst_d != '0);
        pass_d = pass_d && !port_reset_d;
        chg_d = chg_d && !port_reset_d;
        bias_1a_d = (mode == usb_port_pkg::MODE_DCP_1);
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dcp_class_q <= 1'b0;
            prst_q <= '0;
            pass_switch_q <= 1'b0;
            charger_switch_q <= 1'b0;
            bias_1a_q <= 1'b0;
            port_reset_q <= 1'b0;
        end
        else
        begin
            dcp_class_q <= dcp_class_d;
            prst_q <= prst_d;
            pass_switch_q <= pass_d;
            charger_switch_q <= chg_d;
            bias_1a_q <= bias_1a_d;
            port_reset_q <= port_reset_d;
        end
    end

    // ----------------------------------------------------------------
    // Error flags, fault and shared alert pin
    // ----------------------------------------------------------------
    logic fault_qual;
    logic [ERR_W-1:0] ec1_prev_q, ec2_prev_q;
    logic [ERR_W-1:0] err_first_d, err_second_d;
    logic alert_oe_n_d;

    fault_qualify #(.DEGLITCH(DEGLITCH_CYCLES), .BLANK(BLANK_CYCLES)) u_fault (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(en_rise),
        .fault_cond(fault_s),
        .fault_q(fault_qual)
    );

    // A read clears for one cycle so the alert visibly drops; a fresh edge in
    // the read cycle still lands, a standing fault sets again next cycle
    always_comb
    begin
        err_first_d = err_first_rd ? (ec1_s & ~ec1_prev_q) : (err_first_q | ec1_s);
        err_second_d = err_second_rd ? (ec2_s & ~ec2_prev_q) : (err_second_q | ec2_s);
        if (IS_REG)
            alert_oe_n_d = !(|(err_first_d & alert_mask_first) ||
                |(err_second_d & alert_mask_second));
        else
            alert_oe_n_d = !attach_s;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ec1_prev_q <= '0;
            ec2_prev_q <= '0;
            err_first_q <= '0;
            err_second_q <= '0;
            fault_pin_o_q <= 1'b0;
            fault_pin_oe_n_q <= 1'b1;
            alert_pin_o_q <= 1'b0;
            alert_pin_oe_n_q <= 1'b1;
        end
        else
        begin
            ec1_prev_q <= ec1_s;
            ec2_prev_q <= ec2_s;
            err_first_q <= err_first_d;
            err_second_q <= err_second_d;
            fault_pin_o_q <= 1'b0; // Open drain only ever pulls low
            fault_pin_oe_n_q <= !fault_qual;
            alert_pin_o_q <= 1'b0;
            alert_pin_oe_n_q <= alert_oe_n_d;
        end
    end
endmodule // usb_port_mode_and_fault_ctrl
`default_nettype wire

// ==== test/usb_port_mode_and_fault_ctrl_assertions.sv ====
// Concurrent checks on the port role and fault block pins
`timescale 1ns/1ps
`default_nettype none
module usb_port_fault_checker #(
    parameter int ERR_W = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic accessory_power_enable,
    input wire logic logic_supply_ok,
    input wire logic port_role_pin,
    input wire logic fault_condition,
    input wire logic [ERR_W-1:0] err_cond_first,
    input wire logic err_first_rd,
    input wire logic [ERR_W-1:0] alert_mask_first,
    input wire logic [ERR_W-1:0] alert_mask_second,
    input wire logic [ERR_W-1:0] err_first_q,
    input wire logic [ERR_W-1:0] err_second_q,
    input wire logic pass_switch_q,
    input wire logic charger_switch_q,
    input wire logic bias_1a_q,
    input wire logic port_reset_q,
    input wire logic [1:0] charge_detect_select_q,
    input wire logic fault_pin_oe_n_q,
    input wire logic alert_pin_oe_n_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Steady conditions, so no fresh edge refills the word early
    sequence steady_read;
        $stable(err_cond_first)[*4] ##0 err_first_rd;
    endsequence
    sequence clear_then_reload;
        ##1 (err_first_q == '0) ##1 (err_first_q == err_cond_first);
    endsequence
    AST_EN_OFF: assert property (!accessory_power_enable[*4] |=> !pass_switch_q && !charger_switch_q)
        else $error("switch closed, enable low");
    AST_SUPPLY_OFF: assert property (!logic_supply_ok[*4] |=> !pass_switch_q && !charger_switch_q)
        else $error("switch closed, supply low");
    AST_ROLE_INVALID: assert property ((accessory_power_enable && logic_supply_ok && port_role_pin)[*5] |=> !pass_switch_q)
        else $error("pass closed, role high");
    AST_PRST_OPEN: assert property (port_reset_q && $past(port_reset_q) |-> !pass_switch_q && !charger_switch_q)
        else $error("switch closed in port reset");
    AST_PRST_LEN: assert property ($rose(port_reset_q) |-> port_reset_q[*6] ##[1:8] !port_reset_q)
        else $error("port reset length wrong");
    AST_BIAS_SEL: assert property ($rose(bias_1a_q) |-> charge_detect_select_q == usb_port_pkg::CD_DCP_1)
        else $error("1 A bias without its code");
    AST_ERR_READ: assert property (steady_read |-> clear_then_reload)
        else $error("read did not clear and reload");
    AST_ALERT_MASK: assert property ($stable(alert_mask_first) && $stable(alert_mask_second) |->
        ((((err_first_q & alert_mask_first) | (err_second_q & alert_mask_second)) != '0) == !alert_pin_oe_n_q))
        else $error("alert differs from masked flags");
    AST_FAULT_RELEASE: assert property (!fault_condition[*8] |=> fault_pin_oe_n_q)
        else $error("fault pin held after clear");
    AST_FAULT_DEGLITCH: assert property ($fell(fault_pin_oe_n_q) |-> $past(fault_condition, 6))
        else $error("fault pin without lasting fault");
endmodule // usb_port_fault_checker
bind usb_port_mode_and_fault_ctrl usb_port_fault_checker #(.ERR_W(ERR_W)) chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .accessory_power_enable(accessory_power_enable),
    .logic_supply_ok(logic_supply_ok), .port_role_pin(port_role_pin),
    .fault_condition(fault_condition), .err_cond_first(err_cond_first),
    .err_first_rd(err_first_rd), .alert_mask_first(alert_mask_first),
    .alert_mask_second(alert_mask_second), .err_first_q(err_first_q),
    .err_second_q(err_second_q), .pass_switch_q(pass_switch_q),
    .charger_switch_q(charger_switch_q), .bias_1a_q(bias_1a_q), .port_reset_q(port_reset_q),
    .charge_detect_select_q(charge_detect_select_q), .fault_pin_oe_n_q(fault_pin_oe_n_q),
    .alert_pin_oe_n_q(alert_pin_oe_n_q)
);
`default_nettype wire

// ==== test/head_unit_host.sv ====
// Head-unit host model: configuration writes and error-word reads
`timescale 1ns/1ps
`default_nettype none
module head_unit_host (
    input wire logic clk_sys,
    input wire logic [7:0] err_first_q,
    input wire logic [7:0] err_second_q,
    output logic host_cfg_wr,
    output logic [1:0] host_cd,
    output logic host_ss_en,
    output logic host_sync_dir,
    output logic err_first_rd,
    output logic err_second_rd
);
    // Idle; each request is a one-cycle strobe
    initial
    begin
        {host_cfg_wr, host_cd, host_ss_en, host_sync_dir, err_first_rd, err_second_rd} = 7'h08;
    end
    // Host write: spread spectrum on, sync pin as input
    task automatic write_cfg(input logic [1:0] cd);
        @(negedge clk_sys);
        host_cfg_wr = 1'b1;
        host_cd = cd;
        @(negedge clk_sys);
        host_cfg_wr = 1'b0;
    endtask
    // Data is the settled word that the strobe's edge then clears
    task automatic read_err(input logic sel, output logic [7:0] data);
        @(negedge clk_sys);
        err_first_rd = !sel;
        err_second_rd = sel;
        data = sel ? err_second_q : err_first_q;
        @(negedge clk_sys);
        {err_first_rd, err_second_rd} = 2'h0;
    endtask
endmodule // head_unit_host
`default_nettype wire

// ==== test/usb_port_mode_and_fault_ctrl_bench.sv ====
// Self-checking bench for the port role and fault block
`timescale 1ns/1ps
`default_nettype none
module usb_port_mode_and_fault_ctrl_bench;
    logic clk_sys, reset_n, en, sup, role, chg, flt, wr, ss, sd, rd1, rd2;
    logic pass, chgsw, b1a, prst, ss_q, sd_q, foe, aoe, fo, ao;
    logic [7:0] ec1, ec2, m1, m2, e1, e2, rdv;
    logic [3:0] s1;
    logic [1:0] hcd, cd_q, addr;
    int err_total, num_checks;
    usb_port_mode_and_fault_ctrl #(.DEGLITCH_CYCLES(4), .BLANK_CYCLES(20),
        .PORT_RESET_CYCLES(8)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .accessory_power_enable(en),
        .logic_supply_ok(sup), .port_role_pin(role), .cdp_charging_state(chg),
        .device_attached(1'b0), .fault_condition(flt), .err_cond_first(ec1),
        .err_cond_second(ec2), .strap_one(s1), .strap_two(s1), .strap_three(s1),
        .host_cfg_wr(wr), .host_cd(hcd), .host_ss_en(ss), .host_sync_dir(sd),
        .err_first_rd(rd1), .err_second_rd(rd2), .alert_mask_first(m1),
        .alert_mask_second(m2), .pass_switch_q(pass), .charger_switch_q(chgsw),
        .bias_1a_q(b1a), .port_reset_q(prst), .charge_detect_select_q(cd_q), .ss_en_q(ss_q),
        .sync_dir_q(sd_q), .addr_lsb_q(addr), .freq_sel_q(), .gain_q(), .ilim_sel_q(),
        .hold_en_q(), .err_first_q(e1), .err_second_q(e2), .fault_pin_o_q(fo),
        .fault_pin_oe_n_q(foe), .alert_pin_o_q(ao), .alert_pin_oe_n_q(aoe));
    head_unit_host host_u (.clk_sys(clk_sys), .err_first_q(e1), .err_second_q(e2),
        .host_cfg_wr(wr), .host_cd(hcd), .host_ss_en(ss), .host_sync_dir(sd),
        .err_first_rd(rd1), .err_second_rd(rd2));
    // Free-running 10 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Switches as {pass, charger}: 2 pass only, 1 charger only
    task automatic sw(input logic [7:0] exp);
        chk({6'h00, pass, chgsw}, exp, "switches");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Fifteen times the two hundred or so cycles needed
    initial
    begin
        #(3000 * 100);
        err_total++;
        tally_and_finish;
    end
    // Roles, straps, error words, fault pin
    initial
    begin
        {reset_n, en, sup, role, chg, flt} = 6'h00;
        {ec1, ec2, m1, m2} = 32'h0000_0000;
        s1 = 4'hD;
        cyc(16);
        reset_n = 1'b1;
        {en, sup} = 2'h3;
        cyc(6);
        chk({6'h00, cd_q}, {6'h00, usb_port_pkg::CD_CDP}, "default select");
        sw(8'h02);
        chk({4'h0, ss_q, sd_q, addr}, 8'h05, "strap one");
        s1 = 4'h0;
        cyc(6);
        chk({4'h0, ss_q, sd_q, addr}, 8'h05, "strap held");
        chg = 1'b1;
        cyc(4);
        sw(8'h01);
        chg = 1'b0;
        host_u.write_cfg(usb_port_pkg::CD_SDP);
        cyc(4);
        sw(8'h02);
        chk({6'h00, ss_q, sd_q}, 8'h02, "host overwrite");
        chk({7'h00, prst}, 8'h00, "same class");
        host_u.write_cfg(usb_port_pkg::CD_DCP_24);
        cyc(3);
        chk({7'h00, prst}, 8'h01, "class reset");
        sw(8'h00);
        cyc(12);
        sw(8'h01);
        chk({7'h00, b1a}, 8'h00, "bias 2.4");
        host_u.write_cfg(usb_port_pkg::CD_DCP_1);
        cyc(4);
        sw(8'h01);
        chk({6'h00, b1a, prst}, 8'h02, "bias 1, no reset");
        host_u.write_cfg(usb_port_pkg::CD_SDP);
        cyc(16);
        role = 1'b1;
        cyc(16);
        sw(8'h01);
        role = 1'b0;
        cyc(16);
        sup = 1'b0;
        cyc(5);
        sw(8'h00);
        sup = 1'b1;
        cyc(16);
        // First error word masked in, second out
        {m1, ec1, ec2} = 24'h01_01_02;
        cyc(4);
        chk({e1[3:0], e2[3:0]}, 8'h12, "flags set");
        chk({7'h00, aoe}, 8'h00, "alert on");
        host_u.read_err(1'b1, rdv);
        chk(rdv, 8'h02, "second word");
        ec1 = 8'h00;
        cyc(3);
        host_u.read_err(1'b0, rdv);
        chk(rdv, 8'h01, "first word");
        cyc(2);
        chk({e1[3:0], 3'h0, aoe}, 8'h01, "cleared");
        ec1 = 8'h01;
        cyc(5);
        host_u.read_err(1'b0, rdv);
        chk({e1[3:0], 3'h0, aoe}, 8'h01, "alert dropped");
        cyc(3);
        chk({e1[3:0], 3'h0, aoe}, 8'h10, "standing refill");
        // Fault pin: glitch ignored, lasting fault held
        flt = 1'b1;
        cyc(2);
        flt = 1'b0;
        cyc(10);
        chk({7'h00, foe}, 8'h01, "glitch");
        flt = 1'b1;
        cyc(16);
        chk({7'h00, foe}, 8'h00, "fault held");
        flt = 1'b0;
        cyc(10);
        chk({5'h00, fo, ao, foe}, 8'h01, "fault freed, drains low");
        en = 1'b0;
        cyc(6);
        sw(8'h00);
        tally_and_finish;
    end
endmodule // usb_port_mode_and_fault_ctrl_bench
`default_nettype wire
